// *** inc/odl_pkg.sv ***
package odl_pkg;

	// ----------------------------------------------------------------
	// widths and reset values
	// ----------------------------------------------------------------
	localparam int          TAP_W        = 5;
	localparam int          CHAIN_DEPTH  = 32;
	localparam logic [4:0]  TAP_RST      = 5'h00;
	localparam logic [4:0]  TAP_STEP     = 5'h01;
	localparam logic [4:0]  STAGING_RST  = 5'h00;
	localparam logic [4:0]  PRESET_RST   = 5'h00;
	localparam int          INV_IDLE_CYC = 2;

	// ----------------------------------------------------------------
	// register map (word addresses on the plain port)
	// ----------------------------------------------------------------
	localparam int          ADDR_W       = 2;
	localparam logic [1:0]  CFG_ADDR     = 2'h0;
	localparam logic [1:0]  STATUS_ADDR  = 2'h1;

	// config field positions
	localparam int          CFG_MODE_LSB = 0;
	localparam int          CFG_SRC_BIT  = 2;
	localparam int          CFG_PRE_LSB  = 3;
	// status field positions
	localparam int          ST_TAP_LSB   = 0;
	localparam int          ST_STG_LSB   = 8;
	localparam int          ST_INV_BIT   = 16;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		fixed_mode,
		step_mode,
		load_mode,
		staged_load_mode
	} delay_mode_e;

	typedef enum logic {
		src_output_logic,
		src_forwarded_clock
	} source_e;

	typedef struct packed {
		logic       tap_load;
		logic       step_enable;
		logic       step_up;
		logic       staging_load_enable;
		logic       staging_clear;
		logic [4:0] tap_value;
	} tap_ctrl_s;

	typedef struct packed {
		logic [4:0]  preset_taps;
		source_e     source_select;
		delay_mode_e mode;
	} delay_cfg_s;

	localparam delay_cfg_s CFG_RST = '{
		preset_taps:   PRESET_RST,
		source_select: src_output_logic,
		mode:          fixed_mode
	};

endpackage : odl_pkg

// *** core/tap_delay_chain.sv ***
`timescale 1ns/1ps
module tap_delay_chain
	import odl_pkg::*;
(
	input  wire logic             core_clk_i,
	input  wire logic             srst_i,
	input  wire logic             source_i,
	input  wire logic [TAP_W-1:0] tap_i,
	output logic                  delayed_o
);

	// ----------------------------------------------------------------
	// sampled stand-in for the analog chain, one stage per tap
	// ----------------------------------------------------------------
	logic [CHAIN_DEPTH-1:0] stage_r;
	wire  logic             tap_pick;

	assign tap_pick = stage_r[tap_i];

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			stage_r   <= '0;
			delayed_o <= 1'b0;
		end else begin
			stage_r   <= {stage_r[CHAIN_DEPTH-2:0], source_i};
			delayed_o <= tap_pick;
		end
	end

endmodule : tap_delay_chain

// *** core/output_delay_tap_control.sv ***
// Overview of operation
// - five-bit tap position, wraps around
// - controls sampled only on control clock
// - step mode load restores preset taps
// - tap_load active high, clock edge
// - load mode copies tap_value_in
// - staged mode copies staging register
// - staging_load_enable captures tap_value_in
// - staging_clear zeroes staging register
// - clock_invert_ctrl flips control edge
// - tap_value_out always shows position
// - step_enable steps one tap per cycle
// - step_enable low holds the tap
// - stepping starts/stops on next edge
// - 31 wraps to 0, 0 to 31
// - stepping ignored in fixed mode
// - delayed_out carries exactly one source
// - one tap_load updates staged lines together
// - preset_taps 0..31, default zero
// - fixed mode holds preset, never changes
// - load modes start from zero
// - source_select picks data or clock
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
module output_delay_tap_control
	import odl_pkg::*;
(
	input  wire logic              core_clk_i,
	input  wire logic              srst_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [31:0]       wr_data_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [31:0]       rd_data_o,
	input  wire logic              tap_load_i,
	input  wire logic              step_enable_i,
	input  wire logic              step_up_i,
	input  wire logic              staging_load_enable_i,
	input  wire logic              staging_clear_i,
	input  wire logic              clock_invert_ctrl_i,
	input  wire logic [TAP_W-1:0]  tap_value_in_i,
	input  wire logic              data_from_output_logic_i,
	input  wire logic              forwarded_clock_in_i,
	output logic      [TAP_W-1:0]  tap_value_out_o,
	output logic                   delayed_out_o
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [TAP_W-1:0] start_tap(delay_cfg_s c);
		start_tap = (c.mode == fixed_mode || c.mode == step_mode) ?
			c.preset_taps : TAP_RST;
	endfunction : start_tap

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	delay_cfg_s       cfg_r;
	delay_cfg_s       cfg_nxt;
	tap_ctrl_s        ctl_raw;
	tap_ctrl_s        ctl_late_r;
	tap_ctrl_s        ctl;
	logic [TAP_W-1:0] tap_r;
	logic [TAP_W-1:0] tap_nxt;
	logic [TAP_W-1:0] staging_r;
	logic [TAP_W-1:0] staging_nxt;
	logic             inv_r;
	logic [31:0]      rd_nxt;
	logic             src_r;

	wire logic cfg_wr;
	wire logic var_mode;
	wire logic do_load;
	wire logic do_step;
	wire logic [TAP_W-1:0] load_val;
	wire logic [TAP_W-1:0] step_val;
	wire logic src_nxt;

	// ----------------------------------------------------------------
	// control capture and polarity
	// ----------------------------------------------------------------
	assign ctl_raw = '{
		tap_load:            tap_load_i,
		step_enable:         step_enable_i,
		step_up:             step_up_i,
		staging_load_enable: staging_load_enable_i,
		staging_clear:       staging_clear_i,
		tap_value:           tap_value_in_i
	};

	// inverted edge lands later; modelled as one extra cycle of lag,
	// so inputs near a flip are ambiguous, hence the idle cycles
	assign ctl = inv_r ? ctl_late_r : ctl_raw;

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			ctl_late_r <= '0;
			inv_r      <= 1'b0;
		end else begin
			ctl_late_r <= ctl_raw;
			inv_r      <= clock_invert_ctrl_i;
		end
	end

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	assign cfg_wr  = wr_i && addr_i == CFG_ADDR;
	assign cfg_nxt = cfg_wr ? delay_cfg_s'(wr_data_i[7:0]) : cfg_r;

	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (rd_i && addr_i == CFG_ADDR)
			rd_nxt[7:0] = cfg_r;
		else if (rd_i && addr_i == STATUS_ADDR) begin
			rd_nxt[ST_TAP_LSB +: TAP_W] = tap_r;
			rd_nxt[ST_STG_LSB +: TAP_W] = staging_r;
			rd_nxt[ST_INV_BIT]          = inv_r;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			cfg_r     <= CFG_RST;
			rd_data_o <= 32'h0000_0000;
		end else begin
			cfg_r     <= cfg_nxt;
			rd_data_o <= rd_nxt;
		end
	end

	// ----------------------------------------------------------------
	// tap counter
	// ----------------------------------------------------------------
	assign var_mode = cfg_r.mode != fixed_mode;
	assign do_load  = var_mode && ctl.tap_load;
	assign do_step  = var_mode && ctl.step_enable;

	// natural 5-bit overflow gives the wrap both ways
	assign step_val = ctl.step_up ? tap_r + TAP_STEP
	                              : tap_r - TAP_STEP;

	assign load_val = (cfg_r.mode == load_mode)  ? ctl.tap_value
	                : (cfg_r.mode == staged_load_mode) ? staging_r
	                : cfg_r.preset_taps;

	always_comb begin
		if (cfg_wr)
			tap_nxt = start_tap(cfg_nxt);
		else if (!var_mode)
			tap_nxt = cfg_r.preset_taps;
		else if (do_load)
			tap_nxt = load_val;
		else if (do_step)
			tap_nxt = step_val;
		else
			tap_nxt = tap_r;
	end

	// ----------------------------------------------------------------
	// staging register, clear beats capture
	// ----------------------------------------------------------------
	assign staging_nxt = ctl.staging_clear       ? STAGING_RST
	                   : ctl.staging_load_enable ? ctl.tap_value
	                   : staging_r;

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			tap_r           <= TAP_RST;
			staging_r       <= STAGING_RST;
			tap_value_out_o <= TAP_RST;
		end else begin
			tap_r           <= tap_nxt;
			staging_r       <= staging_nxt;
			tap_value_out_o <= tap_nxt;
		end
	end

	// ----------------------------------------------------------------
	// source mux and delay chain
	// ----------------------------------------------------------------
	assign src_nxt = (cfg_r.source_select == src_forwarded_clock) ?
		forwarded_clock_in_i : data_from_output_logic_i;

	always_ff @(posedge core_clk_i) begin
		if (srst_i)
			src_r <= 1'b0;
		else
			src_r <= src_nxt;
	end

	tap_delay_chain u_chain (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.source_i   (src_r),
		.tap_i      (tap_r),
		.delayed_o  (delayed_out_o)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_step_up;
		@(posedge core_clk_i) disable iff (srst_i)
		(var_mode && !cfg_wr && !ctl.tap_load && ctl.step_enable
			&& ctl.step_up) |=> tap_r == $past(tap_r) + TAP_STEP;
	endproperty
	a_step_up: assert property (p_step_up)
		else $error("tap did not step up by one");

	property p_step_down;
		@(posedge core_clk_i) disable iff (srst_i)
		(var_mode && !cfg_wr && !ctl.tap_load && ctl.step_enable
			&& !ctl.step_up) |=> tap_r == $past(tap_r) - TAP_STEP;
	endproperty
	a_step_down: assert property (p_step_down)
		else $error("tap did not step down by one");

	property p_hold;
		@(posedge core_clk_i) disable iff (srst_i)
		(!cfg_wr && !ctl.tap_load && !ctl.step_enable)
			|=> $stable(tap_r);
	endproperty
	a_hold: assert property (p_hold)
		else $error("tap moved without enable");

	property p_load_direct;
		@(posedge core_clk_i) disable iff (srst_i)
		(cfg_r.mode == load_mode && !cfg_wr && ctl.tap_load)
			|=> tap_r == $past(ctl.tap_value);
	endproperty
	a_load_direct: assert property (p_load_direct)
		else $error("direct load value wrong");

	property p_load_staged;
		@(posedge core_clk_i) disable iff (srst_i)
		(cfg_r.mode == staged_load_mode && !cfg_wr && ctl.tap_load)
			|=> tap_r == $past(staging_r);
	endproperty
	a_load_staged: assert property (p_load_staged)
		else $error("staged load value wrong");

	property p_load_preset;
		@(posedge core_clk_i) disable iff (srst_i)
		(cfg_r.mode == step_mode && !cfg_wr && ctl.tap_load
			&& ctl.step_enable) |=> tap_r == $past(cfg_r.preset_taps);
	endproperty
	a_load_preset: assert property (p_load_preset)
		else $error("preset load lost to stepping");

	property p_fixed;
		@(posedge core_clk_i) disable iff (srst_i)
		(cfg_r.mode == fixed_mode && !cfg_wr)
			|=> tap_r == $past(cfg_r.preset_taps);
	endproperty
	a_fixed: assert property (p_fixed)
		else $error("fixed tap not at preset");

	property p_staging;
		@(posedge core_clk_i) disable iff (srst_i)
		ctl.staging_clear |=> staging_r == STAGING_RST;
	endproperty
	a_staging: assert property (p_staging)
		else $error("staging clear failed");

	property p_staging_cap;
		@(posedge core_clk_i) disable iff (srst_i)
		(!ctl.staging_clear && ctl.staging_load_enable)
			|=> staging_r == $past(ctl.tap_value);
	endproperty
	a_staging_cap: assert property (p_staging_cap)
		else $error("staging capture wrong");

	// cross-checks the status path against the pin path
	property p_out_tracks;
		@(posedge core_clk_i) disable iff (srst_i)
		(rd_i && addr_i == STATUS_ADDR)
			|=> rd_data_o[ST_TAP_LSB +: TAP_W] == $past(tap_value_out_o);
	endproperty
	a_out_tracks: assert property (p_out_tracks)
		else $error("tap_value_out differs from tap");

	// while inverted, the prior cycle's controls must drive the step
	property p_inv_lag;
		@(posedge core_clk_i) disable iff (srst_i)
		(inv_r && var_mode && !cfg_wr && !ctl_late_r.tap_load
			&& ctl_late_r.step_enable && ctl_late_r.step_up)
			|=> tap_r == $past(tap_r) + TAP_STEP;
	endproperty
	a_inv_lag: assert property (p_inv_lag)
		else $error("inverted control edge not applied");

	property p_load_start;
		@(posedge core_clk_i) disable iff (srst_i)
		(cfg_wr && (cfg_nxt.mode == load_mode
			|| cfg_nxt.mode == staged_load_mode)) |=> tap_r == TAP_RST;
	endproperty
	a_load_start: assert property (p_load_start)
		else $error("load mode did not start at zero");

	property p_src_clock;
		@(posedge core_clk_i) disable iff (srst_i)
		cfg_r.source_select == src_forwarded_clock
			|=> src_r == $past(forwarded_clock_in_i);
	endproperty
	a_src_clock: assert property (p_src_clock)
		else $error("forwarded clock not selected");

endmodule : output_delay_tap_control

// *** verification/fabric_ctrl_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// fabric side of the tap controls
// ------------------------------------------------------------
module fabric_ctrl_model
	import odl_pkg::*;
(
	input  wire logic      core_clk_i, // shared i/o clock net
	input  wire logic      srst_i,
	input  wire tap_ctrl_s cmd_i,
	input  wire logic      invert_i,
	output tap_ctrl_s      ctrl_o,
	output logic           invert_o
);
	logic       inv_r;
	logic [1:0] idle_r;
	logic [1:0] idle_nxt;
	wire        flip = invert_i != inv_r;

	// controls forced idle for the flip cycle plus two more
	assign idle_nxt = flip ? 2'h2
	                : (idle_r != 2'h0 ? idle_r - 2'h1 : 2'h0);
	assign ctrl_o   = (flip || idle_r != 2'h0) ? '0 : cmd_i;
	assign invert_o = invert_i;

	always_ff @(posedge core_clk_i) begin
		inv_r  <= srst_i ? 1'b0 : invert_i;
		idle_r <= srst_i ? 2'h0 : idle_nxt;
	end
endmodule : fabric_ctrl_model

// *** verification/output_delay_tap_control_test.sv ***
`timescale 1ns/1ps
module output_delay_tap_control_test
	import odl_pkg::*;
;
	localparam logic [4:0] F_LOAD = 5'h10;
	localparam logic [4:0] F_STEP = 5'h08;
	localparam logic [4:0] F_UP   = 5'h04;
	localparam logic [4:0] F_STG  = 5'h02;
	localparam logic [4:0] F_CLR  = 5'h01;
	logic              core_clk_i = 1'b0;
	logic              srst_i     = 1'b1;
	logic [ADDR_W-1:0] addr_i     = '0;
	logic [31:0]       wr_data_i  = '0;
	logic              wr_i       = 1'b0;
	logic              rd_i       = 1'b0;
	logic              inv_i      = 1'b0;
	logic              d_in       = 1'b0;
	logic              c_in       = 1'b0;
	tap_ctrl_s         cmd        = '0;
	tap_ctrl_s         ctl;
	logic              inv_o;
	logic [31:0]       rd_data_o;
	logic [TAP_W-1:0]  tap;
	logic              dly;
	int                errors       = 0;
	int                total_checks = 0;

	always #12.5 core_clk_i = ~core_clk_i;

	fabric_ctrl_model u_far (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.cmd_i(cmd), .invert_i(inv_i), .ctrl_o(ctl), .invert_o(inv_o));

	output_delay_tap_control u_dut (.core_clk_i(core_clk_i),
		.srst_i(srst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
		.wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
		.tap_load_i(ctl.tap_load), .step_enable_i(ctl.step_enable),
		.step_up_i(ctl.step_up),
		.staging_load_enable_i(ctl.staging_load_enable),
		.staging_clear_i(ctl.staging_clear), .clock_invert_ctrl_i(inv_o),
		.tap_value_in_i(ctl.tap_value), .data_from_output_logic_i(d_in),
		.forwarded_clock_in_i(c_in), .tap_value_out_o(tap),
		.delayed_out_o(dly));

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: %h expected %h", $time, seen,
				exp);
		end
	endtask : chk

	task automatic wr(input logic [1:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		wr_i      <= 1'b1;
		addr_i    <= a;
		wr_data_i <= d;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask : wr

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [1:0] a, input logic [31:0] exp);
		@(posedge core_clk_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		@(negedge core_clk_i);
		chk(rd_data_o, exp);
	endtask : rd

	task automatic cfg(input logic [1:0] m, input logic s,
		input logic [4:0] p, input logic [4:0] e);
		wr(CFG_ADDR, {24'h0, p, s, m});
		@(negedge core_clk_i);
		chk(32'(tap), 32'(e));
	endtask : cfg

	function automatic tap_ctrl_s ct(input logic [4:0] f,
		input logic [4:0] v);
		return tap_ctrl_s'({f, v});
	endfunction : ct

	// n back-to-back cycles, tap checked each cycle against e + d*i
	task automatic run(input tap_ctrl_s c, input int n,
		input logic [4:0] e, input logic [4:0] d);
		logic [4:0] x;
		@(posedge core_clk_i);
		cmd <= c;
		for (int i = 1; i <= n; i++) begin
			@(posedge core_clk_i);
			if (i == n) cmd <= '0;
			@(negedge core_clk_i);
			x = e + d * 5'(i);
			chk(32'(tap), 32'(x));
		end
	endtask : run

	// unselected source held high, so a wrong pick shows at once
	task automatic lat(input logic s, input logic [4:0] p);
		int n;
		cfg(fixed_mode, s, p, p);
		@(posedge core_clk_i);
		{c_in, d_in} <= s ? 2'h1 : 2'h2;
		@(posedge core_clk_i);
		{c_in, d_in} <= 2'h3;
		@(posedge core_clk_i);
		{c_in, d_in} <= s ? 2'h1 : 2'h2;
		n = 1;
		@(negedge core_clk_i);
		while (dly !== 1'b1 && n < 64) begin
			@(negedge core_clk_i);
			n++;
		end
		chk(32'(n), 32'(p) + 32'h3);
		@(posedge core_clk_i);
		{c_in, d_in} <= 2'h0;
		repeat (40) @(posedge core_clk_i);
	endtask : lat

	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge core_clk_i);
		srst_i <= 1'b0;
		rd(CFG_ADDR, 32'h0);
		wr(STATUS_ADDR, 32'hffffffff);
		wr(2'h3, 32'hffffffff);
		rd(STATUS_ADDR, 32'h0);
		rd(2'h3, 32'h0);
		$display("test reset done");
		cfg(fixed_mode, src_output_logic, 5'h1f, 5'h1f);
		run(ct(F_STEP | F_UP, 5'h0), 3, 5'h1f, 5'h0);
		run(ct(F_LOAD, 5'h3), 1, 5'h1f, 5'h0);
		$display("test fixed done");
		cfg(step_mode, src_output_logic, 5'h1e, 5'h1e);
		run(ct(F_STEP | F_UP, 5'h0), 3, 5'h1e, 5'h1);
		run(ct(F_UP, 5'h0), 3, 5'h1, 5'h0);
		run(ct(F_STEP, 5'h0), 4, 5'h1, 5'h1f);
		run(ct(F_LOAD | F_STEP, 5'h9), 1, 5'h1e, 5'h0);
		$display("test step done");
		cfg(load_mode, src_output_logic, 5'h7, 5'h0);
		run(ct(F_LOAD, 5'h15), 1, 5'h15, 5'h0);
		run(ct(F_LOAD | F_STEP | F_UP, 5'h4), 1, 5'h4, 5'h0);
		run(ct(F_STEP | F_UP, 5'h0), 2, 5'h4, 5'h1);
		$display("test load done");
		cfg(staged_load_mode, src_output_logic, 5'h7, 5'h0);
		run(ct(F_STG, 5'h0a), 1, 5'h0, 5'h0);
		rd(STATUS_ADDR, 32'h0a00);
		run(ct(F_LOAD, 5'h11), 1, 5'h0a, 5'h0);
		run(ct(F_STG | F_CLR, 5'h13), 1, 5'h0a, 5'h0);
		rd(STATUS_ADDR, 32'h000a);
		run(ct(F_LOAD, 5'h0), 1, 5'h0, 5'h0);
		$display("test staged done");
		@(posedge core_clk_i);
		inv_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		rd(STATUS_ADDR, 32'h10000);
		// inverted edge: the step lands one cycle late
		run(ct(F_STEP | F_UP, 5'h0), 1, 5'h0, 5'h0);
		run(ct(F_UP, 5'h0), 1, 5'h1, 5'h0);
		@(posedge core_clk_i);
		inv_i <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		run(ct(F_STEP | F_UP, 5'h0), 1, 5'h1, 5'h1);
		$display("test invert done");
		lat(src_output_logic, 5'h0);
		lat(src_forwarded_clock, 5'h1f);
		$display("test delay done");
		stop_test;
	end

	initial begin
		repeat (5000) @(posedge core_clk_i);
		errors++;
		stop_test;
	end
endmodule : output_delay_tap_control_test
